// *** verilog/eddb_top.sv ***
`timescale 1ns/1ps
module eddb_top (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic cmd_valid_i,
  input wire logic [3:0] cmd_code_i,
  input wire logic [47:0] tap_data_i,
  input wire logic [7:0] diag_i,
  input wire logic sclk_i,
  output logic txd_o,
  output logic io_o,
  output logic io_oe_o,
  output logic detect_off_o,
  output logic cap_busy_o,
  output logic burst_busy_o
);
  // ----------------------------------------------------------------
  // types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b01,
    CAP_RUN = 2'b10
  } eddb_cap_t;

  typedef enum logic [4:0] {
    B_IDLE = 5'b00001,
    B_DIAG = 5'b00010,
    B_DATA = 5'b00100,
    B_SUM = 5'b01000,
    B_DRAIN = 5'b10000
  } eddb_burst_t;

  function automatic logic [7:0] ck_add(input logic [7:0] s,
                                         input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, s} + {1'b0, b};
    ck_add = t[7:0] + {7'h00, t[8]};
  endfunction : ck_add

  function automatic logic [11:0] nl_scale(input logic [11:0] x);
    nl_scale = x;
    if (x > eddb_pkg::KNEE) begin
      nl_scale = eddb_pkg::KNEE + {2'b00, x[11:2]} - {2'b00, eddb_pkg::KNEE[11:2]};
    end
  endfunction : nl_scale

  function automatic logic [11:0] tap_pick(input logic [47:0] d,
                                           input logic [2:0] sel);
    tap_pick = 12'h000;
    case (sel)
      3'h1: tap_pick = nl_scale(d[11:0]);
      3'h2: tap_pick = d[23:12];
      3'h3: tap_pick = d[35:24];
      3'h4: tap_pick = d[47:36];
      default: tap_pick = 12'h000;
    endcase
  endfunction : tap_pick

  function automatic logic [7:0] narrow(input logic [11:0] x,
                                        input logic lp,
                                        input logic [1:0] g);
    narrow = x[11:4];
    if (lp) begin
      case (g)
        2'h0: narrow = x[11:4];
        2'h1: narrow = x[10:3];
        2'h2: narrow = x[9:2];
        default: narrow = x[8:1];
      endcase
    end else if (g != 2'h0) begin
      narrow = x[7:0];
    end
  endfunction : narrow

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] reclen_reg;
  logic [7:0] mem [0:eddb_pkg::MEM_DEPTH-1];
  logic [6:0] rptr_reg;
  logic cap_done_reg;
  logic [6:0] tick_reg;
  logic tick;
  logic sclk_m_reg;
  logic sclk_s_reg;
  logic sclk_d_reg;
  eddb_cap_t cap_reg;
  logic [9:0] glen_reg;
  logic [9:0] gcnt_reg;
  logic [6:0] loc_reg;
  logic [7:0] peak_reg;
  eddb_burst_t bst_reg;
  logic [16:0] nsamp_reg;
  logic [16:0] scnt_reg;
  logic phase_reg;
  logic [3:0] roll_reg;
  logic [7:0] sum_reg;
  logic [7:0] pend0_reg;
  logic [7:0] pend1_reg;
  logic [1:0] pcnt_reg;
  logic cap_en;
  logic [2:0] tap_sel;
  logic wide;
  logic [1:0] gain;
  logic burst_en;
  logic is_meas;
  logic is_burst_cmd;
  logic cap_start;
  logic cap_end;
  logic burst_start;
  logic [3:0] rec_sel;
  logic [11:0] cur;
  logic [7:0] cap_val;
  logic pop;

  eddb_ser_if lnk ();

  eddb_ser u_ser (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .lnk(lnk.ser)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign cap_en = ctrl_reg[eddb_pkg::CAP_EN_BIT];
  assign tap_sel = ctrl_reg[eddb_pkg::TAP_LSB +: 3];
  assign wide = ctrl_reg[eddb_pkg::WIDE_BIT];
  assign gain = ctrl_reg[eddb_pkg::GAIN_LSB +: 2];
  assign burst_en = (tap_sel > eddb_pkg::TAP_OFF) &&
                    (tap_sel < eddb_pkg::TAP_LIMIT);
  assign rec_sel = ctrl_reg[eddb_pkg::PRESET_BIT] ?
                   reclen_reg[eddb_pkg::P2_LSB +: 4] :
                   reclen_reg[eddb_pkg::P1_LSB +: 4];
  assign is_meas = cmd_valid_i && (cmd_code_i == eddb_pkg::CMD_BL_P1 ||
                   cmd_code_i == eddb_pkg::CMD_BL_P2 ||
                   cmd_code_i == eddb_pkg::CMD_LO_P1 ||
                   cmd_code_i == eddb_pkg::CMD_LO_P2);
  assign is_burst_cmd = cmd_valid_i &&
                        (cmd_code_i == eddb_pkg::CMD_SENDRECV ||
                         cmd_code_i == eddb_pkg::CMD_RECVONLY ||
                         cmd_code_i == eddb_pkg::CMD_TEMPREAD);
  assign cap_start = is_meas && cap_en && (cap_reg == CAP_IDLE);
  assign burst_start = is_burst_cmd && burst_en &&
                       (bst_reg == B_IDLE);
  assign cur = tap_pick(tap_data_i, tap_sel);
  assign cap_val = narrow(tap_pick(tap_data_i, eddb_pkg::LOWPASS_TAP), 1'b1,
                          2'h0);
  assign cap_end = tick && (cap_reg == CAP_RUN) && (gcnt_reg == glen_reg) &&
                   (loc_reg == 7'(eddb_pkg::MEM_DEPTH - 1));
  assign detect_off_o = cap_en || burst_en;
  assign cap_busy_o = (cap_reg == CAP_RUN);
  assign burst_busy_o = (bst_reg != B_IDLE);
  assign io_o = 1'b0;
  assign io_oe_o = (cap_reg == CAP_RUN);
  assign txd_o = lnk.txd;

  // ----------------------------------------------------------------
  // microsecond sample tick
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      tick_reg <= 7'h00;
    end else if (tick_reg == 7'(eddb_pkg::SAMPLE_CYC - 1)) begin
      tick_reg <= 7'h00;
    end else begin
      tick_reg <= tick_reg + 7'h01;
    end
  end
  assign tick = (tick_reg == 7'(eddb_pkg::SAMPLE_CYC - 1));

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ctrl_reg <= eddb_pkg::CTRL_RST;
      reclen_reg <= eddb_pkg::RECLEN_RST;
    end else if (wr_i) begin
      if (addr_i == eddb_pkg::CTRL_OFS) begin
        ctrl_reg <= wdata_i;
      end
      if (addr_i == eddb_pkg::RECLEN_OFS) begin
        reclen_reg <= wdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        eddb_pkg::CTRL_OFS: rdata_o <= ctrl_reg;
        eddb_pkg::RECLEN_OFS: rdata_o <= reclen_reg;
        eddb_pkg::STAT_OFS: rdata_o <= {4'h0, detect_off_o, burst_busy_o,
                                        cap_done_reg, cap_busy_o};
        eddb_pkg::CAPDATA_OFS: rdata_o <= mem[rptr_reg];
        eddb_pkg::CAPPTR_OFS: rdata_o <= {1'b0, rptr_reg};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // capture readback pointer and done flag
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rptr_reg <= 7'h00;
    end else if (cmd_valid_i && cmd_code_i == eddb_pkg::CMD_CAPREAD) begin
      rptr_reg <= 7'h00;
    end else if (rd_i && addr_i == eddb_pkg::CAPDATA_OFS) begin
      rptr_reg <= rptr_reg + 7'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cap_done_reg <= 1'b0;
    end else if (cap_end) begin
      cap_done_reg <= 1'b1;
    end else if (cap_start ||
                 (cmd_valid_i && cmd_code_i == eddb_pkg::CMD_CAPREAD)) begin
      cap_done_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // capture cycle
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cap_reg <= CAP_IDLE;
      glen_reg <= 10'h000;
      gcnt_reg <= 10'h000;
      loc_reg <= 7'h00;
      peak_reg <= 8'h00;
    end else begin
      case (cap_reg)
        CAP_IDLE: begin
          if (cap_start) begin
            cap_reg <= CAP_RUN;
            glen_reg <= 10'(({6'h00, rec_sel} + 10'h001) *
                        10'(eddb_pkg::GROUP_STEP)) - 10'h001;
            gcnt_reg <= 10'h000;
            loc_reg <= 7'h00;
            peak_reg <= 8'h00;
          end
        end
        CAP_RUN: begin
          if (tick) begin
            if (gcnt_reg == glen_reg) begin
              gcnt_reg <= 10'h000;
              peak_reg <= 8'h00;
              loc_reg <= loc_reg + 7'h01;
              if (cap_end) begin
                cap_reg <= CAP_IDLE;
              end
            end else begin
              gcnt_reg <= gcnt_reg + 10'h001;
              if (cap_val > peak_reg) begin
                peak_reg <= cap_val;
              end
            end
          end
        end
        default: cap_reg <= CAP_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (tick && cap_reg == CAP_RUN && gcnt_reg == glen_reg) begin
      mem[loc_reg] <= (cap_val > peak_reg) ? cap_val : peak_reg;
    end
  end

  // ----------------------------------------------------------------
  // link clock sampling
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sclk_m_reg <= 1'b0;
      sclk_s_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_m_reg <= sclk_i;
      sclk_s_reg <= sclk_m_reg;
      sclk_d_reg <= sclk_s_reg;
    end
  end
  assign lnk.clk_fall = sclk_d_reg && !sclk_s_reg;

  // ----------------------------------------------------------------
  // burst byte queue toward the serializer
  // ----------------------------------------------------------------
  assign lnk.byte_valid = (pcnt_reg != 2'h0);
  assign lnk.byte_data = pend0_reg;
  assign pop = lnk.byte_valid && lnk.byte_ready;

  // ----------------------------------------------------------------
  // burst sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      bst_reg <= B_IDLE;
      nsamp_reg <= 17'h0_0000;
      scnt_reg <= 17'h0_0000;
      phase_reg <= 1'b0;
      roll_reg <= 4'h0;
      sum_reg <= eddb_pkg::CK_SEED;
      pend0_reg <= 8'h00;
      pend1_reg <= 8'h00;
      pcnt_reg <= 2'h0;
    end else begin
      if (pop) begin
        pend0_reg <= pend1_reg;
        pcnt_reg <= pcnt_reg - 2'h1;
      end
      case (bst_reg)
        B_IDLE: begin
          if (burst_start) begin
            bst_reg <= B_DIAG;
            nsamp_reg <= 17'(({13'h0000, rec_sel} + 17'h0_0001) *
                         17'(eddb_pkg::REC_STEP_US));
            scnt_reg <= 17'h0_0000;
            phase_reg <= 1'b0;
            roll_reg <= 4'h0;
            sum_reg <= eddb_pkg::CK_SEED;
          end
        end
        B_DIAG: begin
          pend0_reg <= diag_i;
          pcnt_reg <= 2'h1;
          sum_reg <= ck_add(eddb_pkg::CK_SEED, diag_i);
          bst_reg <= B_DATA;
        end
        B_DATA: begin
          if (scnt_reg == nsamp_reg) begin
            bst_reg <= B_SUM;
          end else if (tick) begin
            scnt_reg <= scnt_reg + 17'h0_0001;
            phase_reg <= ~phase_reg;
            if (!wide) begin
              if (pcnt_reg - {1'b0, pop} == 2'h0) begin
                pend0_reg <= narrow(cur, tap_sel == eddb_pkg::LOWPASS_TAP,
                                    gain);
              end else begin
                pend1_reg <= narrow(cur, tap_sel == eddb_pkg::LOWPASS_TAP,
                                    gain);
              end
              pcnt_reg <= pcnt_reg - {1'b0, pop} + 2'h1;
              sum_reg <= ck_add(sum_reg, narrow(cur,
                         tap_sel == eddb_pkg::LOWPASS_TAP, gain));
            end else if (!phase_reg) begin
              pend0_reg <= cur[7:0];
              pend1_reg <= {roll_reg, cur[11:8]};
              pcnt_reg <= 2'h2;
              roll_reg <= roll_reg + 4'h1;
              sum_reg <= ck_add(ck_add(sum_reg, cur[7:0]),
                                {roll_reg, cur[11:8]});
            end
          end
        end
        B_SUM: begin
          if (pcnt_reg - {1'b0, pop} == 2'h0) begin
            pend0_reg <= ~sum_reg;
            pcnt_reg <= 2'h1;
            bst_reg <= B_DRAIN;
          end
        end
        B_DRAIN: begin
          if (pcnt_reg == 2'h0 && !lnk.busy) begin
            bst_reg <= B_IDLE;
          end
        end
        default: bst_reg <= B_IDLE;
      endcase
    end
  end
endmodule : eddb_top

// *** pkg/eddb_pkg.sv ***
// Notes on behaviour
// - with capture enabled, any of four measure commands starts a capture cycle
// - one-wire pin is held low for the whole capture record interval
// - capture-memory read command returns the stored capture bytes
// - capture store is 128 bytes; record interval split evenly over them
// - each location keeps the peak sample of its group
// - record length 0x01 means 8192 us; groups fill locations in order
// - data path gives one sample per microsecond; base for both modes
// - capture enable suppresses object detection and measurement results
// - tap select 1 to 4 enables bursting and suppresses detection
// - burst leaves only through the clocked usart transmit pin
// - burst commands serialize selected tap eight to one on transmit pin
// - stream is diagnostic byte, data bytes, then checksum over all
// - sample count equals record interval in microseconds
// - 8-bit width: one byte per sample, bits picked by gain select
// - 12-bit width: every second sample, low byte first, counter in high
// - nonlinear scaling only on the low-pass tap
package eddb_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int SAMPLE_NS = 1000;
  localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
  localparam int REC_STEP_US = 4096;
  localparam int MEM_DEPTH = 128;
  localparam int GROUP_STEP = REC_STEP_US / MEM_DEPTH;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] RECLEN_OFS = 8'h01;
  localparam logic [7:0] STAT_OFS = 8'h02;
  localparam logic [7:0] CAPDATA_OFS = 8'h03;
  localparam logic [7:0] CAPPTR_OFS = 8'h04;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RECLEN_RST = 8'h11;
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CAP_EN_BIT = 0;
  localparam int TAP_LSB = 1;
  localparam int WIDE_BIT = 4;
  localparam int GAIN_LSB = 5;
  localparam int PRESET_BIT = 7;
  localparam int P1_LSB = 0;
  localparam int P2_LSB = 4;
  // ----------------------------------------------------------------
  // tap select values
  // ----------------------------------------------------------------
  localparam logic [2:0] TAP_OFF = 3'h0;
  localparam logic [2:0] LOWPASS_TAP = 3'h1;
  localparam logic [2:0] TAP_LIMIT = 3'h5;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_BL_P1 = 4'h0;
  localparam logic [3:0] CMD_BL_P2 = 4'h1;
  localparam logic [3:0] CMD_LO_P1 = 4'h2;
  localparam logic [3:0] CMD_LO_P2 = 4'h3;
  localparam logic [3:0] CMD_SENDRECV = 4'h4;
  localparam logic [3:0] CMD_RECVONLY = 4'h5;
  localparam logic [3:0] CMD_TEMPREAD = 4'h6;
  localparam logic [3:0] CMD_CAPREAD = 4'h7;
  // ----------------------------------------------------------------
  // misc
  // ----------------------------------------------------------------
  localparam logic [11:0] KNEE = 12'h800;
  localparam logic [7:0] CK_SEED = 8'h00;
endpackage : eddb_pkg

// *** pkg/eddb_ser_if.sv ***
`timescale 1ns/1ps
interface eddb_ser_if;
  logic [7:0] byte_data;
  logic byte_valid;
  logic byte_ready;
  logic clk_fall;
  logic busy;
  logic txd;
  modport ctl (
    output byte_data, byte_valid, clk_fall,
    input byte_ready, busy, txd
  );
  modport ser (
    input byte_data, byte_valid, clk_fall,
    output byte_ready, busy, txd
  );
endinterface : eddb_ser_if

// *** verilog/eddb_ser.sv ***
`timescale 1ns/1ps
module eddb_ser (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  eddb_ser_if.ser lnk
);
  // ----------------------------------------------------------------
  // eight to one shifter, lsb first
  // ----------------------------------------------------------------
  logic [7:0] shift_reg;
  logic [3:0] left_reg;

  assign lnk.busy = (left_reg != 4'h0);
  assign lnk.byte_ready = (left_reg == 4'h0);
  assign lnk.txd = (left_reg != 4'h0) ? shift_reg[0] : 1'b1;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      shift_reg <= 8'h00;
      left_reg <= 4'h0;
    end else if (left_reg == 4'h0) begin
      if (lnk.byte_valid) begin
        shift_reg <= lnk.byte_data;
        left_reg <= 4'h8;
      end
    end else if (lnk.clk_fall) begin
      shift_reg <= {1'b1, shift_reg[7:1]};
      left_reg <= left_reg - 4'h1;
    end
  end
endmodule : eddb_ser

// *** bench/eddb_top_asserts.sv ***
`timescale 1ns/1ps
module eddb_top_asserts (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic cmd_valid_i,
  input wire logic [3:0] cmd_code_i,
  input wire logic [47:0] tap_data_i,
  input wire logic [7:0] diag_i,
  input wire logic sclk_i,
  input wire logic txd_o,
  input wire logic io_o,
  input wire logic io_oe_o,
  input wire logic detect_off_o,
  input wire logic cap_busy_o,
  input wire logic burst_busy_o
);
  // ----------------------------------------------------------------
  // control shadow
  // ----------------------------------------------------------------
  logic [7:0] ctl_reg;
  logic [2:0] tap;
  logic tap_ok;
  logic msr;
  logic brq;
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ctl_reg <= eddb_pkg::CTRL_RST;
    end else if (wr_i && addr_i == eddb_pkg::CTRL_OFS) begin
      ctl_reg <= wdata_i;
    end
  end
  assign tap = ctl_reg[eddb_pkg::TAP_LSB +: 3];
  assign tap_ok = tap != eddb_pkg::TAP_OFF && tap < eddb_pkg::TAP_LIMIT;
  assign msr = cmd_valid_i && cmd_code_i <= eddb_pkg::CMD_LO_P2;
  assign brq = cmd_valid_i && cmd_code_i >= eddb_pkg::CMD_SENDRECV &&
               cmd_code_i <= eddb_pkg::CMD_TEMPREAD;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  chk_io_low: assert property (io_oe_o |-> !io_o && cap_busy_o)
    else $error("io pin not held low by a capture");
  chk_cap_hold: assert property ($rose(cap_busy_o) |=> cap_busy_o [*8])
    else $error("capture ended early");
  chk_cap_start: assert property (msr && ctl_reg[0] && !cap_busy_o &&
    !burst_busy_o |=> cap_busy_o && io_oe_o)
    else $error("measure command did not start capture");
  chk_cap_off: assert property (msr && !ctl_reg[0] && !cap_busy_o
    |=> !cap_busy_o)
    else $error("capture started while disabled");
  chk_detect_off: assert property (detect_off_o == (ctl_reg[0] || tap_ok))
    else $error("detect off flag wrong");
  chk_burst_start: assert property (brq && tap_ok && !burst_busy_o &&
    !cap_busy_o |=> burst_busy_o)
    else $error("burst command not taken");
  chk_burst_refuse: assert property (cmd_valid_i && !tap_ok &&
    !burst_busy_o |=> !burst_busy_o)
    else $error("burst started with tap off");
  chk_txd_idle: assert property (!burst_busy_o && !$past(burst_busy_o)
    |-> txd_o)
    else $error("txd not idle high");
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  chk_ctrl_read: assert property ($past(rd_i) &&
    $past(addr_i) == eddb_pkg::CTRL_OFS |-> rdata_o == $past(ctl_reg))
    else $error("control readback wrong");
  cov_cap: cover property (msr && ctl_reg[0]);
  cov_burst: cover property (brq && tap_ok);
  cov_unmap: cover property ($past(rd_i) && $past(addr_i) > 8'h04);
endmodule : eddb_top_asserts

// *** bench/eddb_host_model.sv ***
`timescale 1ns/1ps
module eddb_host_model (
  input wire logic run_i,
  input wire logic txd_i,
  output logic sclk_o,
  output logic [7:0] rx_byte_o,
  output logic [15:0] rx_cnt_o
);
  // ----------------------------------------------------------------
  // link clock and byte capture
  // ----------------------------------------------------------------
  logic [7:0] sh;
  int nb;
  initial begin
    sclk_o = 1'b0;
    rx_byte_o = 8'h00;
    rx_cnt_o = 16'h0000;
    sh = 8'h00;
    nb = 0;
  end
  // clock runs only inside a frame, parks low
  always begin
    #62.5;
    if (run_i || sclk_o) begin
      sclk_o = ~sclk_o;
    end
  end
  always @(posedge run_i) begin
    nb = 0;
  end
  // lsb first, eight bits to a byte
  always @(posedge sclk_o) begin
    sh = {txd_i, sh[7:1]};
    nb++;
    if (nb == 8) begin
      rx_byte_o = sh;
      rx_cnt_o++;
      nb = 0;
    end
  end
endmodule : eddb_host_model

// *** bench/eddb_tb_top.sv ***
`timescale 1ns/1ps
module eddb_tb_top;
  typedef struct packed {
    logic [2:0] sel;
    logic [1:0] gain;
    logic wide;
    logic [3:0] code;
    logic [11:0] tv;
    logic [7:0] e0;
    logic [3:0] e1;
    logic go;
  } eddb_row_t;
  logic mclk_i = 1'b0;
  logic rst_b_i, wr_i, rd_i, cmd_valid_i, sclk_i, txd_o, io_o, io_oe_o;
  logic detect_off_o, cap_busy_o, burst_busy_o, run;
  logic [7:0] addr_i, wdata_i, rdata_o, diag_i, rx_byte, dg;
  logic [3:0] cmd_code_i;
  logic [47:0] tap_data_i, tb;
  logic [15:0] rx_cnt;
  logic [7:0] rxb [0:4];
  eddb_row_t r;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  eddb_row_t rows [10] = '{
    '{3'h2, 2'h0, 1'b0, 4'h4, 12'hA5C, 8'hA5, 4'h0, 1'b1},
    '{3'h2, 2'h1, 1'b0, 4'h5, 12'hA5C, 8'h5C, 4'h0, 1'b1},
    '{3'h1, 2'h0, 1'b0, 4'h6, 12'h3C6, 8'h3C, 4'h0, 1'b1},
    '{3'h1, 2'h2, 1'b0, 4'h4, 12'h3C6, 8'hF1, 4'h0, 1'b1},
    '{3'h1, 2'h0, 1'b0, 4'h5, 12'hC00, 8'h90, 4'h0, 1'b1},
    '{3'h3, 2'h0, 1'b0, 4'h6, 12'hC00, 8'hC0, 4'h0, 1'b1},
    '{3'h4, 2'h0, 1'b1, 4'h4, 12'h9B7, 8'hB7, 4'h9, 1'b1},
    '{3'h5, 2'h0, 1'b0, 4'h4, 12'h123, 8'h00, 4'h0, 1'b0},
    '{3'h0, 2'h0, 1'b0, 4'h5, 12'h123, 8'h00, 4'h0, 1'b0},
    '{3'h2, 2'h0, 1'b0, 4'h7, 12'h123, 8'h00, 4'h0, 1'b0}};
  always #5 mclk_i = ~mclk_i;
  eddb_top dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .tap_data_i(tap_data_i), .diag_i(diag_i), .sclk_i(sclk_i),
    .txd_o(txd_o), .io_o(io_o), .io_oe_o(io_oe_o),
    .detect_off_o(detect_off_o), .cap_busy_o(cap_busy_o),
    .burst_busy_o(burst_busy_o));
  eddb_host_model host (.run_i(run), .txd_i(txd_o), .sclk_o(sclk_i),
    .rx_byte_o(rx_byte), .rx_cnt_o(rx_cnt));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic do_rst;
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
  endtask : do_rst
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask : reg_rd
  task automatic send_cmd(input logic [3:0] c);
    @(posedge mclk_i);
    cmd_code_i <= c;
    cmd_valid_i <= 1'b1;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    #1;
  endtask : send_cmd
  task automatic grab;
    int k;
    logic [15:0] last;
    k = 0;
    last = rx_cnt;
    for (int t = 0; t < 3000 && k < 5; t++) begin
      @(posedge mclk_i);
      if (rx_cnt != last) begin
        rxb[k] = rx_byte;
        k++;
        last = rx_cnt;
      end
    end
    chk(8'(k), 8'h05);
  endtask : grab
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_code_i = 4'h0;
    tap_data_i = 48'h0000_0000_0000;
    diag_i = 8'h00;
    run = 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      dg = 8'h30 + 8'(i);
      do_rst;
      tb = 48'hFFFF_FFFF_FFFF;
      if (r.go) begin
        tb[(r.sel - 3'h1) * 12 +: 12] = r.tv;
      end
      tap_data_i <= tb;
      diag_i <= dg;
      reg_wr(eddb_pkg::CTRL_OFS, {1'b0, r.gain, r.wide, r.sel, 1'b0});
      send_cmd(r.code);
      chk({7'h0, burst_busy_o}, {7'h0, r.go});
      chk({7'h0, detect_off_o}, {7'h0, r.sel != 3'h0 && r.sel < 3'h5});
      if (r.go) begin
        repeat (3) @(posedge mclk_i);
        run <= 1'b1;
        grab;
        run <= 1'b0;
        chk(rxb[0], dg);
        chk(rxb[1], r.e0);
        if (r.wide) begin
          chk({4'h0, rxb[2][3:0]}, {4'h0, r.e1});
          chk(rxb[3], r.e0);
          chk({4'h0, rxb[4][7:4]}, {4'h0, rxb[2][7:4] + 4'h1});
        end else begin
          chk(rxb[4], r.e0);
        end
      end
    end
    do_rst;
    reg_rd(eddb_pkg::CTRL_OFS, 8'h00);
    reg_rd(eddb_pkg::RECLEN_OFS, 8'h11);
    reg_rd(8'h40, 8'h00);
    reg_wr(eddb_pkg::STAT_OFS, 8'hFF);
    reg_rd(eddb_pkg::STAT_OFS, 8'h00);
    send_cmd(eddb_pkg::CMD_BL_P1);
    chk({7'h0, cap_busy_o}, 8'h00);
    for (int c = 0; c < 4; c++) begin
      reg_wr(eddb_pkg::CTRL_OFS, 8'h01);
      reg_rd(eddb_pkg::STAT_OFS, 8'h08);
      send_cmd(4'(c));
      chk({4'h0, io_oe_o, io_o, cap_busy_o, detect_off_o}, 8'h0B);
      repeat (300) @(posedge mclk_i);
      reg_rd(eddb_pkg::STAT_OFS, 8'h09);
      do_rst;
    end
    reg_wr(eddb_pkg::CTRL_OFS, 8'h01);
    tap_data_i <= 48'h0000_0000_0123;
    send_cmd(eddb_pkg::CMD_LO_P1);
    repeat (3000) @(posedge mclk_i);
    tap_data_i <= 48'h0000_0000_03C6;
    repeat (200) @(posedge mclk_i);
    tap_data_i <= 48'h0000_0000_0123;
    repeat (3500) @(posedge mclk_i);
    send_cmd(eddb_pkg::CMD_CAPREAD);
    reg_rd(eddb_pkg::CAPDATA_OFS, 8'h3C);
    reg_rd(eddb_pkg::CAPPTR_OFS, 8'h01);
    reg_wr(eddb_pkg::RECLEN_OFS, 8'h5A);
    reg_rd(eddb_pkg::RECLEN_OFS, 8'h5A);
    tally_and_finish;
  end
endmodule : eddb_tb_top
bind eddb_top eddb_top_asserts u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
  .tap_data_i(tap_data_i), .diag_i(diag_i), .sclk_i(sclk_i),
  .txd_o(txd_o), .io_o(io_o), .io_oe_o(io_oe_o),
  .detect_off_o(detect_off_o), .cap_busy_o(cap_busy_o),
  .burst_busy_o(burst_busy_o));
